// ### rtl/ilgc_top.sv
// ldo / load-switch control, serial slave and multi-function output
// assumes pins arrive asynchronous; open-drain wires resolved outside
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
module ilgc_top #(
  parameter int CYC_MS = ilgc_pkg::CYC_PER_MS,
  parameter int WDOG = ilgc_pkg::WDOG_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // monitored conditions
  input wire logic chip_enable_pin_i,
  input wire logic supply_uv_i,
  input wire logic conv_ov_i,
  input wire logic conv_oc_i,
  input wire logic conv_uv_i,
  input wire logic ldo_fault_i,
  // regulator and converter control
  output logic [4:0] regulator_voltage_code_o,
  output logic [11:0] ldo_mv_o,
  output logic ldo_enable_o,
  output logic ldo_load_switch_o,
  output logic ldo_discharge_o,
  output logic buck_enable_o,
  // multi-function open-drain output
  output logic multi_function_output_pin_o,
  output logic multi_function_output_pin_oe_n_o
);
  import ilgc_pkg::*;
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [7:0] s1_ff, s2_ff;
  logic [1:0] q_ff;
  logic scl_s, sda_s, ce_s, uv_s, ov_s, oc_s, cuv_s, flt_s;
  logic start, stop, scl_rise, scl_fall;
  // two stages per pin, plus a third on scl and sda for edge detection; the first stage is never read by logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
      q_ff <= 2'h3;
    end else begin
      s1_ff <= {scl_i, sda_i, chip_enable_pin_i, supply_uv_i, conv_ov_i, conv_oc_i, conv_uv_i, ldo_fault_i};
      s2_ff <= s1_ff;
      q_ff <= s2_ff[7:6];
    end
  end
  assign {scl_s, sda_s, ce_s, uv_s, ov_s, oc_s, cuv_s, flt_s} = s2_ff;
  // oversampled edges keep the engine rate independent
  assign start = scl_s & q_ff[1] & q_ff[0] & ~sda_s;
  assign stop = scl_s & q_ff[1] & ~q_ff[0] & sda_s;
  assign scl_rise = scl_s & ~q_ff[1];
  assign scl_fall = ~scl_s & q_ff[1];
  // ----------------------------------------
  // register file and shared write port
  // ----------------------------------------
  logic [7:0] evt_ff, mask_ff, gpo_cfg_ff, buck_ff, ldo_ff;
  logic i2c_wr_ff;
  logic [7:0] i2c_widx_ff, sh_ff;
  logic wb_go, wr_en;
  logic [7:0] wb_idx, wr_idx, wr_dat, set_v, clr_v;
  function automatic logic [7:0] rd_reg(input logic [7:0] idx);
    unique case (idx)
      EVT_IDX: rd_reg = evt_ff;
      STAT_IDX: rd_reg = {1'b0, uv_s, 1'b0, oc_s, ov_s, cuv_s, 1'b0, buck_ff[EN_BIT]};
      MASK_IDX: rd_reg = mask_ff;
      GPO_IDX: rd_reg = gpo_cfg_ff;
      BUCK_IDX: rd_reg = buck_ff;
      LDO_IDX: rd_reg = ldo_ff;
      default: rd_reg = 8'h00;
    endcase
  endfunction : rd_reg
  // a serial write owns the port for its one cycle; the bus waits
  assign wb_idx = {2'h0, wb_adr_i[7:2]};
  assign wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~i2c_wr_ff;
  assign wr_en = i2c_wr_ff | (wb_go & wb_we_i & wb_sel_i[0] & (wb_adr_i[1:0] == 2'h0));
  assign wr_idx = i2c_wr_ff ? i2c_widx_ff : wb_idx;
  assign wr_dat = i2c_wr_ff ? sh_ff : wb_dat_i[7:0];
  // wishbone answers one cycle after the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_go;
      if (wb_go) begin
        wb_dat_o <= {24'h00_0000, rd_reg(wb_idx)};
      end
    end
  end
  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= MASK_RST;
      gpo_cfg_ff <= 8'h00;
      buck_ff <= 8'h00;
      ldo_ff <= 8'h00;
    end else if (wr_en) begin
      if (wr_idx == MASK_IDX) mask_ff <= wr_dat & MASK_RST;
      if (wr_idx == GPO_IDX) gpo_cfg_ff <= wr_dat;
      if (wr_idx == BUCK_IDX) buck_ff <= wr_dat;
      // code held while enabled; enable bit always writable
      if (wr_idx == LDO_IDX) ldo_ff <= {wr_dat[7], 2'h0, ldo_ff[EN_BIT] ? ldo_ff[4:0] : wr_dat[4:0]};
    end
  end
  // sticky flags: mask gates only the set, and a set beats a clear
  assign set_v = {1'b0, uv_s, 1'b0, {3{buck_ff[EN_BIT]}} & {oc_s, ov_s, cuv_s}, 2'h0} & ~mask_ff & EVT_BITS;
  assign clr_v = (wr_en && wr_idx == EVT_IDX) ? wr_dat : 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) evt_ff <= 8'h00;
    else evt_ff <= (evt_ff & ~clr_v) | set_v;
  end
  // ----------------------------------------
  // regulator outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ldo_enable_o <= 1'b0;
      ldo_load_switch_o <= 1'b0;
      ldo_discharge_o <= 1'b1;
      ldo_mv_o <= MV_BASE;
    end else begin
      ldo_enable_o <= ldo_ff[EN_BIT] & ce_s & ~flt_s;
      ldo_load_switch_o <= ldo_ff[4:0] >= LS_MIN_CODE;
      ldo_discharge_o <= ~ce_s | flt_s;
      // load-switch codes report zero: no regulated level exists
      ldo_mv_o <= (ldo_ff[4:0] >= LS_MIN_CODE) ? 12'h000 : 12'(MV_BASE + MV_STEP * {7'h00, ldo_ff[4:0]});
    end
  end
  assign regulator_voltage_code_o = ldo_ff[4:0];
  assign buck_enable_o = buck_ff[EN_BIT];
  // ----------------------------------------
  // bus watchdog
  // ----------------------------------------
  logic wd_run_ff, wd_exp;
  logic [31:0] wd_cnt_ff;
  logic wd_end;
  assign wd_end = wd_run_ff && (wd_cnt_ff == 32'(WDOG - 1));
  assign wd_exp = wd_end & ~sda_s;
  always_ff @(posedge clk_i) begin
    if (rst_i || stop || wd_end) begin
      wd_run_ff <= 1'b0;
      wd_cnt_ff <= 32'h0000_0000;
    end else if (start) begin
      wd_run_ff <= 1'b1;
      wd_cnt_ff <= 32'h0000_0000;
    end else if (wd_run_ff) begin
      wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
    end
  end
  // ----------------------------------------
  // serial slave engine
  // ----------------------------------------
  ilgc_st_t st_ff;
  logic [3:0] cnt_ff;
  logic [1:0] byte_n_ff;
  logic rw_ff, drv_ff;
  logic [7:0] ptr_ff, rd_byte;
  always_comb rd_byte = rd_reg(ptr_ff); // next byte to send
  // never drives the clock; sda only pulled low, changed while scl low
  always_ff @(posedge clk_i) begin
    if (rst_i || stop || wd_exp) begin
      st_ff <= S_IDLE;
      drv_ff <= 1'b0;
      cnt_ff <= 4'h0;
      i2c_wr_ff <= 1'b0;
      if (rst_i) begin
        sh_ff <= 8'h00;
        ptr_ff <= 8'h00;
        byte_n_ff <= 2'h0;
        rw_ff <= 1'b0;
        i2c_widx_ff <= 8'h00;
      end
    end else if (start) begin
      st_ff <= S_RX;
      drv_ff <= 1'b0;
      cnt_ff <= 4'h0;
      byte_n_ff <= 2'h0;
      i2c_wr_ff <= 1'b0;
    end else begin
      i2c_wr_ff <= 1'b0;
      unique case (st_ff)
        S_IDLE: begin
        end
        S_RX: begin
          if (scl_rise && cnt_ff < BITS_PER_BYTE) begin
            sh_ff <= {sh_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
            cnt_ff <= 4'h0;
            if (byte_n_ff != 2'h0) begin
              drv_ff <= 1'b1;
              st_ff <= S_ACK;
              if (byte_n_ff == 2'h1) begin
                ptr_ff <= sh_ff;
              end else begin
                i2c_wr_ff <= 1'b1;
                i2c_widx_ff <= ptr_ff;
                ptr_ff <= ptr_ff + 8'h01;
              end
            end else if (sh_ff[7:1] == SLV_ADDR) begin
              rw_ff <= sh_ff[0];
              drv_ff <= 1'b1;
              st_ff <= S_ACK;
            end else begin
              st_ff <= S_IDLE;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            byte_n_ff <= (byte_n_ff == 2'h2) ? 2'h2 : byte_n_ff + 2'h1;
            if (rw_ff) begin
              sh_ff <= rd_byte;
              drv_ff <= ~rd_byte[7];
              ptr_ff <= ptr_ff + 8'h01;
              cnt_ff <= 4'h1;
              st_ff <= S_TX;
            end else begin
              drv_ff <= 1'b0;
              st_ff <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_ff == BITS_PER_BYTE) begin
              drv_ff <= 1'b0;
              st_ff <= S_RACK;
            end else begin
              drv_ff <= ~sh_ff[6];
              sh_ff <= {sh_ff[6:0], 1'b0};
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        S_RACK: begin
          // a master ack reuses the ack state to load the next byte; a nack ends the read
          if (scl_rise) begin
            st_ff <= sda_s ? S_IDLE : S_ACK;
          end
        end
      endcase
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~drv_ff;
  // ----------------------------------------
  // reset pulse timer and output function
  // ----------------------------------------
  logic src, src_q_ff, done_ff, pull;
  logic [31:0] pre_ff;
  logic [6:0] ms_ff, tgt_ms;
  ilgc_fn_t fn;
  assign src = gpo_cfg_ff[7] ? ldo_ff[EN_BIT] : buck_ff[EN_BIT];
  assign tgt_ms = (gpo_cfg_ff[6:4] == 3'h0) ? RST_MS_MIN : {gpo_cfg_ff[6:4], 4'h0};
  // pulse timed from the enable bit written to one
  always_ff @(posedge clk_i) begin
    if (rst_i || !src || !src_q_ff) begin
      src_q_ff <= !rst_i && src;
      done_ff <= 1'b0;
      pre_ff <= 32'h0000_0000;
      ms_ff <= 7'h00;
    end else if (!done_ff) begin
      if (pre_ff == 32'(CYC_MS - 1)) begin
        pre_ff <= 32'h0000_0000;
        ms_ff <= ms_ff + 7'h01;
        done_ff <= (ms_ff + 7'h01) == tgt_ms;
      end else begin
        pre_ff <= pre_ff + 32'h0000_0001;
      end
    end
  end
  assign fn = ilgc_fn_t'(gpo_cfg_ff[3:0]);
  always_comb begin
    pull = 1'b0;
    unique case (fn)
      FN_HIZ: pull = 1'b0;
      FN_LOW: pull = 1'b1;
      FN_PG_HI: pull = uv_s;
      FN_PG_LO: pull = ~uv_s;
      FN_EVENT: pull = |(evt_ff & EVT_BITS);
      FN_RST: pull = ~done_ff;
      default: pull = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) multi_function_output_pin_oe_n_o <= 1'b1;
    else multi_function_output_pin_oe_n_o <= ~pull;
  end
  assign multi_function_output_pin_o = 1'b0;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_code_hold: assert property (ldo_ff[EN_BIT] |=> ldo_ff[4:0] == $past(ldo_ff[4:0]))
    else $error("code changed while enabled");
  a_ls_mode: assert property ((ldo_ff[4:0] >= LS_MIN_CODE) |=> ldo_load_switch_o)
    else $error("load switch mode missed");
  a_mv_decode: assert property ((ldo_ff[4:0] == 5'h1A) |=> ldo_mv_o == 12'hCE4)
    else $error("top code not 3.3 V");
  a_dischg_ce: assert property (!ce_s |=> ldo_discharge_o && !ldo_enable_o)
    else $error("no discharge with enable low");
  a_stop_idle: assert property (stop |=> st_ff == S_IDLE && !drv_ff)
    else $error("stop did not idle engine");
  a_wdog_reset: assert property (wd_exp |=> st_ff == S_IDLE ##1 !sda_oe_n_o == 1'b0)
    else $error("watchdog did not reset engine");
  a_addr_miss: assert property ((st_ff == S_RX && scl_fall && cnt_ff == 4'h8 && byte_n_ff == 2'h0
    && sh_ff[7:1] != SLV_ADDR && !stop && !start && !wd_exp) |=> st_ff == S_IDLE && !drv_ff)
    else $error("acked foreign address");
  a_evt_sticky: assert property ((evt_ff[6] && clr_v[6] == 1'b0) |=> evt_ff[6])
    else $error("flag dropped without clear");
  a_mask_block: assert property ((mask_ff[4] && !evt_ff[4] && !$past(wr_en)) |=> !evt_ff[4])
    else $error("masked flag was set");
  a_gpo_low: assert property ((fn == FN_LOW) |=> !multi_function_output_pin_oe_n_o)
    else $error("fixed low not driven");
endmodule : ilgc_top

// ### rtl/ilgc_pkg.sv
// constants, types and register map of the ldo / gpo control block
// assumes a 100 MHz system clock and byte-wide registers on word slots
package ilgc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] EVT_IDX = 8'h00;
  localparam logic [7:0] STAT_IDX = 8'h02;
  localparam logic [7:0] MASK_IDX = 8'h03;
  localparam logic [7:0] GPO_IDX = 8'h04;
  localparam logic [7:0] BUCK_IDX = 8'h05;
  localparam logic [7:0] LDO_IDX = 8'h07;
  // reset values and field layouts
  localparam logic [7:0] MASK_RST = 8'h7C;
  localparam logic [7:0] EVT_BITS = 8'h5C;
  localparam int EN_BIT = 7;
  localparam logic [7:0] SYNC_RST = 8'hC0;
  // serial bus
  localparam logic [6:0] SLV_ADDR = 7'h2F;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // regulator code decode, in millivolts
  localparam logic [4:0] LS_MIN_CODE = 5'h1B;
  localparam logic [11:0] MV_BASE = 12'h2BC;
  localparam logic [11:0] MV_STEP = 12'h064;
  // reset pulse and watchdog timing
  localparam int CLK_HZ = 32'h05F5_E100;
  localparam int MS_PER_S = 32'h0000_03E8;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam logic [6:0] RST_MS_MIN = 7'h08;
  localparam int WDOG_MS = 32'h0000_0019;
  localparam int WDOG_CYC = WDOG_MS * CYC_PER_MS;
  // output function select
  typedef enum logic [3:0] {FN_HIZ, FN_LOW, FN_PG_HI, FN_PG_LO, FN_EVENT, FN_RST} ilgc_fn_t;
  // serial engine states
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK} ilgc_st_t;
endpackage : ilgc_pkg

// ### tb/ilgc_host_model.sv
// i2c bus master model standing in for the host processor
// assumes sda is pulled up and resolved by the bench
module ilgc_host_model (
  // pacing clock
  input wire logic clk_i,
  // bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // quarter of a serial period in system cycles; 2 gives the 80 ns clock
  int k = 2;
  // released lines idle high; the clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic q();
    repeat (k) @(posedge clk_i);
  endtask : q
  // start: data falls while the clock is high
  task automatic start();
    sda_o <= 1'b0;
    q();
    q();
    scl_o <= 1'b0;
    q();
  endtask : start
  // stop: data rises while the clock is high
  task automatic stop();
    sda_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    sda_o <= 1'b1;
    q();
    q();
  endtask : stop
  // data changes only while the clock is low, sampled mid high phase
  task automatic xbit(input logic b, output logic r);
    sda_o <= b;
    q();
    scl_o <= 1'b1;
    q();
    r = sda_i;
    q();
    scl_o <= 1'b0;
    q();
  endtask : xbit
  // eight bits most significant first, then the acknowledge bit
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r[i]);
    end
    xbit(last, a);
  endtask : xbyte
  // stuck-low data line, used to provoke the bus watchdog
  task automatic hold_low(input int n);
    sda_o <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask : hold_low
endmodule : ilgc_host_model

// ### tb/tb.sv
// self-checking bench for the ldo / gpo control block
// assumes the package and the host model are compiled before it
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ilgc_pkg::*;
  localparam int CMS = 10;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, scl, sda_h, dev_sda, sda_oe_n;
  logic ce, flt, en, ls, dis, buck, multi_function_output_pin, gpo_oe_n;
  logic [3:0] cond, wb_sel_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [4:0] code;
  logic [11:0] mv;
  int errors = 0;
  int checks = 0;
  // wired-and of the data line with its pull-up
  wire logic sda_w = sda_h & (sda_oe_n | dev_sda);
  typedef struct packed {logic [4:0] c; logic [11:0] mv; logic ls;} ilgc_row_t;
  ilgc_row_t rows [5] = '{'{5'h00, 12'h2BC, 1'b0}, '{5'h05, 12'h4B0, 1'b0}, '{5'h1A, 12'hCE4, 1'b0},
    '{5'h1B, 12'h000, 1'b1}, '{5'h1F, 12'h000, 1'b1}};
  logic [7:0] ev [4] = '{8'h04, 8'h08, 8'h10, 8'h40};
  ilgc_top #(.CYC_MS(CMS), .WDOG(2000)) u_ilgc_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .scl_i(scl), .sda_i(sda_w), .sda_o(dev_sda), .sda_oe_n_o(sda_oe_n), .chip_enable_pin_i(ce),
    .supply_uv_i(cond[3]), .conv_ov_i(cond[1]), .conv_oc_i(cond[2]), .conv_uv_i(cond[0]),
    .ldo_fault_i(flt), .regulator_voltage_code_o(code), .ldo_mv_o(mv), .ldo_enable_o(en),
    .ldo_load_switch_o(ls), .ldo_discharge_o(dis), .buck_enable_o(buck),
    .multi_function_output_pin_o(multi_function_output_pin), .multi_function_output_pin_oe_n_o(gpo_oe_n));
  ilgc_host_model u_ilgc_host_model (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, 12'(e), 12'(q));
  endtask : rd
  task automatic fn(input logic [7:0] v, input logic e);
    wr(8'h10, v);
    repeat (4) @(posedge clk_i);
    chk("gpo pin", 12'(e), 12'(gpo_oe_n));
  endtask : fn
  // serial write of the regulator register, then pointer set and read back
  task automatic ser(input int k, input logic [7:0] d);
    logic [7:0] r;
    logic a;
    u_ilgc_host_model.k = k;
    u_ilgc_host_model.start();
    u_ilgc_host_model.xbyte(8'h5E, 1'b1, r, a);
    chk("addr ack", 12'h0, 12'(a));
    u_ilgc_host_model.xbyte(8'h07, 1'b1, r, a);
    u_ilgc_host_model.xbyte(d, 1'b1, r, a);
    chk("data ack", 12'h0, 12'(a));
    u_ilgc_host_model.stop();
    rd(8'h1C, d, "ldo reg");
    u_ilgc_host_model.start();
    u_ilgc_host_model.xbyte(8'h5E, 1'b1, r, a);
    u_ilgc_host_model.xbyte(8'h07, 1'b1, r, a);
    u_ilgc_host_model.stop();
    u_ilgc_host_model.start();
    u_ilgc_host_model.xbyte(8'h5F, 1'b1, r, a);
    u_ilgc_host_model.xbyte(8'hFF, 1'b1, r, a);
    chk("read byte", 12'(d), 12'(r));
    u_ilgc_host_model.stop();
    u_ilgc_host_model.k = 2;
  endtask : ser
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // hang guard, far beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    wrap_up();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] r;
    logic a;
    {rst_i, ce, flt, cond, wb_we_i, wb_cyc_i, wb_stb_i} = 10'h300;
    wb_sel_i = 4'hF;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    repeat (20) @(posedge clk_i);
    chk("rst discharge", 12'h1, 12'(dis));
    chk("rst gpo", 12'h1, 12'(gpo_oe_n));
    chk("pin levels", 12'h0, 12'({multi_function_output_pin, dev_sda, buck}));
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(8'h0C, 8'h7C, "mask rst");
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h00, "unmapped");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(8'h1C, {3'h0, rows[i].c});
      repeat (3) @(posedge clk_i);
      chk("code", 12'(rows[i].c), 12'(code));
      chk("mv", rows[i].mv, mv);
      chk("ls", 12'(rows[i].ls), 12'(ls));
    end
    $display("test decode done");
    wr(8'h1C, 8'h85);
    wr(8'h1C, 8'h83);
    rd(8'h1C, 8'h85, "locked code");
    chk("ldo en", 12'h1, 12'(en));
    ce <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("ce dis", 12'h1, 12'(dis));
    ce <= 1'b1;
    flt <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("flt dis", 12'h1, 12'(dis));
    chk("flt en", 12'h0, 12'(en));
    flt <= 1'b0;
    wr(8'h1C, 8'h00);
    wr(8'h1C, 8'h1B);
    wr(8'h1C, 8'h9B);
    repeat (3) @(posedge clk_i);
    chk("switch on", 12'h1, 12'(en & ls));
    wr(8'h1C, 8'h1B);
    repeat (3) @(posedge clk_i);
    chk("switch off", 12'h0, 12'(en));
    wr(8'h1C, 8'h00);
    $display("test regulator done");
    ser(2, 8'h12);
    ser(8, 8'h0A);
    u_ilgc_host_model.start();
    u_ilgc_host_model.xbyte(8'h5C, 1'b1, r, a);
    chk("foreign ack", 12'h1, 12'(a));
    u_ilgc_host_model.stop();
    u_ilgc_host_model.start();
    u_ilgc_host_model.xbyte(8'h5E, 1'b1, r, a);
    u_ilgc_host_model.xbyte(8'h07, 1'b1, r, a);
    for (int i = 0; i < 4; i++) u_ilgc_host_model.xbit(1'b1, a);
    u_ilgc_host_model.stop();
    rd(8'h1C, 8'h0A, "abort");
    u_ilgc_host_model.start();
    u_ilgc_host_model.xbyte(8'h5E, 1'b1, r, a);
    u_ilgc_host_model.hold_low(2100);
    u_ilgc_host_model.xbyte(8'h07, 1'b1, r, a);
    chk("wdog ack", 12'h1, 12'(a));
    u_ilgc_host_model.stop();
    $display("test serial done");
    wr(8'h0C, 8'h00);
    wr(8'h14, 8'h80);
    chk("buck en", 12'h1, 12'(buck));
    fn(8'h04, 1'b1);
    for (int i = 0; i < 4; i++) begin
      cond <= 4'h1 << i;
      repeat (6) @(posedge clk_i);
      cond <= 4'h0;
      repeat (6) @(posedge clk_i);
      chk("event pin", 12'h0, 12'(gpo_oe_n));
      rd(8'h00, ev[i], "event");
      wr(8'h00, ev[i]);
      repeat (4) @(posedge clk_i);
      chk("event clr", 12'h1, 12'(gpo_oe_n));
    end
    wr(8'h0C, 8'h7C);
    cond <= 4'hC;
    repeat (6) @(posedge clk_i);
    rd(8'h08, 8'h51, "status");
    rd(8'h00, 8'h00, "masked");
    fn(8'h02, 1'b0);
    fn(8'h03, 1'b1);
    cond <= 4'h0;
    fn(8'h03, 1'b0);
    fn(8'h01, 1'b0);
    fn(8'h00, 1'b1);
    $display("test events done");
    wr(8'h14, 8'h00);
    fn(8'h15, 1'b0);
    wr(8'h14, 8'h80);
    repeat (16 * CMS - 6) @(posedge clk_i);
    chk("pulse low", 12'h0, 12'(gpo_oe_n));
    repeat (12) @(posedge clk_i);
    chk("pulse end", 12'h1, 12'(gpo_oe_n));
    fn(8'h85, 1'b0);
    wr(8'h1C, 8'h80);
    repeat (8 * CMS - 6) @(posedge clk_i);
    chk("ldo pulse", 12'h0, 12'(gpo_oe_n));
    repeat (12) @(posedge clk_i);
    chk("ldo pulse end", 12'h1, 12'(gpo_oe_n));
    $display("test pulse done");
    wrap_up();
  end
endmodule : tb
